// *** pkg/dtc_params.svh ***
/*
  Constants of the dual timer/counter block: special-function-register
  addresses, control-bit positions and reset values.
  Assumes it is included by bare name after the package that holds the types.
*/
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// register addresses in the special-function-register space
`define DTC_ADDR_TCTRL   8'h88
`define DTC_ADDR_TMODE   8'h89
`define DTC_ADDR_T0LOW   8'h8A
`define DTC_ADDR_T1LOW   8'h8B
`define DTC_ADDR_T0HIGH  8'h8C
`define DTC_ADDR_T1HIGH  8'h8D
`define DTC_ADDR_SYSCTL  8'hB4

// timer_ctrl_flags bit positions
`define DTC_T1_OVF_BIT   7
`define DTC_T1_RUN_BIT   6
`define DTC_T0_OVF_BIT   5
`define DTC_T0_RUN_BIT   4
`define DTC_IRQ1_EDG_BIT 3
`define DTC_IRQ1_TYP_BIT 2
`define DTC_IRQ0_EDG_BIT 1
`define DTC_IRQ0_TYP_BIT 0

// timer_mode_select bit positions (timer 1 in the upper nibble)
`define DTC_T1_GATE_BIT  7
`define DTC_T1_CT_BIT    6
`define DTC_T1_MODE_HI   5
`define DTC_T1_MODE_LO   4
`define DTC_T0_GATE_BIT  3
`define DTC_T0_CT_BIT    2
`define DTC_T0_MODE_HI   1
`define DTC_T0_MODE_LO   0

// system_control clock-source fields
`define DTC_T1_SEL_HI    7
`define DTC_T1_SEL_LO    6
`define DTC_T0_SEL_HI    5
`define DTC_T0_SEL_LO    4

// reset values
`define DTC_TCTRL_RST    8'h00
`define DTC_TMODE_RST    8'h00
`define DTC_SYSCTL_RST   8'h00
`define DTC_COUNT_RST    8'h00

// legacy-mode prescaler width in bits
`define DTC_PSC_BITS     5

`endif

// *** pkg/dtc_pkg.sv ***
/*
  Types shared by the dual timer/counter files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dtc_pkg;

  // count mode of one timer
  typedef enum logic [1:0] {
    DTC_MODE_LEGACY,
    DTC_MODE_WIDE,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  // clock source chosen in system_control
  typedef enum logic [1:0] {
    DTC_SRC_PSC,
    DTC_SRC_PIN,
    DTC_SRC_STROBE,
    DTC_SRC_PER
  } dtc_src_t;

  // one timer's pair of count bytes
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_cnt_t;

  // result of one count step
  typedef struct packed {
    dtc_cnt_t cnt;
    logic     ovf;
  } dtc_step_t;

  // per-tick events that feed one timer's source selector
  typedef struct packed {
    logic psc;
    logic pin;
    logic strobe;
    logic per;
  } dtc_ticks_t;

endpackage : dtc_pkg

// *** src/dtc_tick_sel.sv ***
/*
  Count-source selector of one timer: picks the one-cycle tick that
  advances the count.
  Assumes every tick input is a single-cycle pulse on core_clk.
*/
`timescale 1ns/100ps

module dtc_tick_sel
  import dtc_pkg::*;
(
  // source pulses
  input  wire dtc_ticks_t ticks,
  // selection
  input  wire logic       ct_sel,
  input  wire dtc_src_t   src_sel,
  // result
  output wire logic       tick
);

  ////////////////////////////////////////////////////////////////////////////
  // multiplexer behind the counter/timer bit
  wire logic mux_tick;

  // system_control picks one of four sources
  assign mux_tick = (src_sel == DTC_SRC_PSC)    ? ticks.psc    :
                    (src_sel == DTC_SRC_PIN)    ? ticks.pin    :
                    (src_sel == DTC_SRC_STROBE) ? ticks.strobe : ticks.per;

  // the counter bit forces the external pin ahead of the multiplexer
  assign tick = ct_sel ? ticks.pin : mux_tick;

endmodule // dtc_tick_sel

// *** src/dtc_top.sv ***
/*
  Dual timer/counter with control, mode and clock-source registers and the
  two external-interrupt type and edge flags.
  Assumes a single-master register port on core_clk; pins and the two
  prescaler clocks arrive asynchronously; strobes and acks are core_clk pulses.
*/
`timescale 1ns/100ps
`include "dtc_params.svh"

module dtc_top
  import dtc_pkg::*;
(
  // clock and reset
  input  wire  logic       core_clk,
  input  wire  logic       arst_n,
  // register port
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic       sfr_wr,
  input  wire  logic       sfr_rd,
  input  wire  logic [7:0] sfr_wdata,
  output logic       [7:0] sfr_rdata,
  // asynchronous pins and prescaler clocks
  input  wire  logic       ext_irq0_pin,
  input  wire  logic       ext_irq1_pin,
  input  wire  logic       t0_count_pin,
  input  wire  logic       t1_count_pin,
  input  wire  logic       psc_clk,
  input  wire  logic       per_clk,
  // cpu strobes and interrupt acknowledges
  input  wire  logic       program_fetch_strobe,
  input  wire  logic       instr_strobe,
  input  wire  logic       t0_vector_ack,
  input  wire  logic       t1_vector_ack,
  input  wire  logic       irq0_ack,
  input  wire  logic       irq1_ack,
  // flags
  output logic             t0_overflow_flag,
  output logic             t1_overflow_flag,
  output logic             ext_irq0_edge_flag,
  output logic             ext_irq1_edge_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] tctrl_reg, tctrl_next;
  logic [7:0] tmode_reg;
  logic [7:0] sysctl_reg;
  dtc_cnt_t   t0_reg, t0_next;
  dtc_cnt_t   t1_reg, t1_next;
  logic [7:0] rdata_reg, rdata_next;

  // synchronisers: irq0, irq1, t0 pin, t1 pin, psc, per
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] sync3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers plus one delay stage for edge detection; presets are low for the count pins and high for
  // irq, psc and per, so only an irq pin held low through reset gives a false edge afterwards
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= 6'h33;
      sync2_reg <= 6'h33;
      sync3_reg <= 6'h33;
    end
    else
    begin
      sync1_reg <= {per_clk, psc_clk, t1_count_pin, t0_count_pin, ext_irq1_pin, ext_irq0_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // pin levels and edges; count pins advance on a falling edge
  wire logic ext_irq0_pin_lvl  = sync2_reg[0];
  wire logic ext_irq1_pin_lvl  = sync2_reg[1];
  wire logic ext_irq0_pin_fall = sync3_reg[0] & ~sync2_reg[0];
  wire logic ext_irq1_pin_fall = sync3_reg[1] & ~sync2_reg[1];
  wire logic t0_pin_tk = sync3_reg[2] & ~sync2_reg[2];
  wire logic t1_pin_tk = sync3_reg[3] & ~sync2_reg[3];
  wire logic psc_tk    = ~sync3_reg[4] & sync2_reg[4];  // one tick per prescaler rising edge
  wire logic per_tk    = ~sync3_reg[5] & sync2_reg[5];

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire logic wr_tctrl  = sfr_wr && (sfr_addr == `DTC_ADDR_TCTRL);
  wire logic wr_tmode  = sfr_wr && (sfr_addr == `DTC_ADDR_TMODE);
  wire logic wr_sysctl = sfr_wr && (sfr_addr == `DTC_ADDR_SYSCTL);
  wire logic wr_t0low  = sfr_wr && (sfr_addr == `DTC_ADDR_T0LOW);
  wire logic wr_t0high = sfr_wr && (sfr_addr == `DTC_ADDR_T0HIGH);
  wire logic wr_t1low  = sfr_wr && (sfr_addr == `DTC_ADDR_T1LOW);
  wire logic wr_t1high = sfr_wr && (sfr_addr == `DTC_ADDR_T1HIGH);

  // control fields, timer 1 upper nibble and timer 0 lower nibble
  wire dtc_mode_t mode0 = dtc_mode_t'(tmode_reg[`DTC_T0_MODE_HI:`DTC_T0_MODE_LO]);
  wire dtc_mode_t mode1 = dtc_mode_t'(tmode_reg[`DTC_T1_MODE_HI:`DTC_T1_MODE_LO]);
  wire logic      run0  = tctrl_reg[`DTC_T0_RUN_BIT];
  wire logic      run1  = tctrl_reg[`DTC_T1_RUN_BIT];
  wire logic      split = (mode0 == DTC_MODE_SPLIT);

  // gating: run alone, or run and a high interrupt pin
  wire logic en0 = run0 & (~tmode_reg[`DTC_T0_GATE_BIT] | ext_irq0_pin_lvl);
  wire logic en1 = run1 & (~tmode_reg[`DTC_T1_GATE_BIT] | ext_irq1_pin_lvl);

  ////////////////////////////////////////////////////////////////////////////
  // clock-source selection per timer
  wire logic tick0;
  wire logic tick1;

  dtc_tick_sel u_sel0 (
    .ticks   ({psc_tk, t0_pin_tk, instr_strobe, per_tk}),
    .ct_sel  (tmode_reg[`DTC_T0_CT_BIT]),
    .src_sel (dtc_src_t'(sysctl_reg[`DTC_T0_SEL_HI:`DTC_T0_SEL_LO])),
    .tick    (tick0)
  );

  dtc_tick_sel u_sel1 (
    .ticks   ({psc_tk, t1_pin_tk, program_fetch_strobe, per_tk}),
    .ct_sel  (tmode_reg[`DTC_T1_CT_BIT]),
    .src_sel (dtc_src_t'(sysctl_reg[`DTC_T1_SEL_HI:`DTC_T1_SEL_LO])),
    .tick    (tick1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one count step for modes 00, 01 and 10
  function automatic dtc_step_t dtc_step(input dtc_mode_t m, input dtc_cnt_t c);
    dtc_step_t r;
    logic      carry;
    r     = '{cnt: c, ovf: 1'b0};
    carry = 1'b0;
    unique case (m)
      DTC_MODE_LEGACY:
      begin
        // low five bits prescale; the upper three low bits are left alone
        r.cnt.low[`DTC_PSC_BITS-1:0] = c.low[`DTC_PSC_BITS-1:0] + 5'h01;
        carry = &c.low[`DTC_PSC_BITS-1:0];
        if (carry)
          r.cnt.high = c.high + 8'h01;
        r.ovf = carry & (&c.high);
      end
      DTC_MODE_WIDE:
      begin
        {r.ovf, r.cnt} = {1'b0, c} + 17'h00001;
      end
      DTC_MODE_RELOAD:
      begin
        r.ovf = &c.low;
        // high byte is the reload source and never changes here
        r.cnt.low = r.ovf ? c.high : c.low + 8'h01;
      end
      DTC_MODE_SPLIT:
      begin
        r = '{cnt: c, ovf: 1'b0};
      end
    endcase
    return r;
  endfunction

  wire dtc_step_t st0 = dtc_step(mode0, t0_reg);
  wire dtc_step_t st1 = dtc_step(mode1, t1_reg);

  // split mode: low byte on timer 0 controls, high byte a timer on run1
  wire logic       split_lo_tk = split & en0 & tick0;
  wire logic       split_hi_tk = split & run1 & psc_tk;
  wire logic [8:0] split_lo    = {1'b0, t0_reg.low} + 9'h001;
  wire logic [8:0] split_hi    = {1'b0, t0_reg.high} + 9'h001;

  // overflow events of the cycle
  wire logic t0_adv  = ~split & en0 & tick0;
  wire logic t1_adv  = (mode1 != DTC_MODE_SPLIT) & en1 & tick1;
  wire logic t0_ovf  = (t0_adv & st0.ovf) | (split_lo_tk & split_lo[8]);
  // with timer 0 split, its high byte owns the timer 1 flag
  wire logic t1_ovf  = split ? (split_hi_tk & split_hi[8]) : (t1_adv & st1.ovf);

  ////////////////////////////////////////////////////////////////////////////
  // next count values; a software write to a byte wins over counting
  always_comb
  begin
    t0_next = t0_reg;  // a stopped timer keeps its bytes
    if (t0_adv)
      t0_next = st0.cnt;
    if (split_lo_tk)
      t0_next.low = split_lo[7:0];
    if (split_hi_tk)
      t0_next.high = split_hi[7:0];
    if (wr_t0low)
      t0_next.low = sfr_wdata;
    if (wr_t0high)
      t0_next.high = sfr_wdata;
  end

  always_comb
  begin
    t1_next = t1_reg;  // mode 11 on timer 1 lands here and holds
    if (t1_adv)
      t1_next = st1.cnt;
    if (wr_t1low)
      t1_next.low = sfr_wdata;
    if (wr_t1high)
      t1_next.high = sfr_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flag events: level type sets while the pin is low, edge type on a falling edge; both latch
  wire logic irq0_set = tctrl_reg[`DTC_IRQ0_TYP_BIT] ? ~ext_irq0_pin_lvl : ext_irq0_pin_fall;
  wire logic irq1_set = tctrl_reg[`DTC_IRQ1_TYP_BIT] ? ~ext_irq1_pin_lvl : ext_irq1_pin_fall;

  // software clears a flag by writing zero to it
  wire logic [7:0] sw_clr = wr_tctrl ? ~sfr_wdata : 8'h00;
  wire logic [7:0] sw_set = wr_tctrl ? sfr_wdata  : 8'h00;

  // hardware sets beat every clear that lands in the same cycle
  always_comb
  begin
    tctrl_next = wr_tctrl ? sfr_wdata : tctrl_reg;  // run and type bits
    tctrl_next[`DTC_T0_OVF_BIT] = t0_ovf | sw_set[`DTC_T0_OVF_BIT] |
      (tctrl_reg[`DTC_T0_OVF_BIT] & ~t0_vector_ack & ~sw_clr[`DTC_T0_OVF_BIT]);
    tctrl_next[`DTC_T1_OVF_BIT] = t1_ovf | sw_set[`DTC_T1_OVF_BIT] |
      (tctrl_reg[`DTC_T1_OVF_BIT] & ~t1_vector_ack & ~sw_clr[`DTC_T1_OVF_BIT]);
    tctrl_next[`DTC_IRQ0_EDG_BIT] = irq0_set | sw_set[`DTC_IRQ0_EDG_BIT] |
      (tctrl_reg[`DTC_IRQ0_EDG_BIT] & ~irq0_ack & ~sw_clr[`DTC_IRQ0_EDG_BIT]);
    tctrl_next[`DTC_IRQ1_EDG_BIT] = irq1_set | sw_set[`DTC_IRQ1_EDG_BIT] |
      (tctrl_reg[`DTC_IRQ1_EDG_BIT] & ~irq1_ack & ~sw_clr[`DTC_IRQ1_EDG_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped addresses read zero
  assign rdata_next = ~sfr_rd                       ? rdata_reg  :
                      (sfr_addr == `DTC_ADDR_TCTRL)  ? tctrl_reg  :
                      (sfr_addr == `DTC_ADDR_TMODE)  ? tmode_reg  :
                      (sfr_addr == `DTC_ADDR_SYSCTL) ? sysctl_reg :
                      (sfr_addr == `DTC_ADDR_T0LOW)  ? t0_reg.low :
                      (sfr_addr == `DTC_ADDR_T0HIGH) ? t0_reg.high :
                      (sfr_addr == `DTC_ADDR_T1LOW)  ? t1_reg.low :
                      (sfr_addr == `DTC_ADDR_T1HIGH) ? t1_reg.high : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // control and configuration registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tctrl_reg  <= `DTC_TCTRL_RST;
      tmode_reg  <= `DTC_TMODE_RST;
      sysctl_reg <= `DTC_SYSCTL_RST;
      rdata_reg  <= 8'h00;
    end
    else
    begin
      tctrl_reg  <= tctrl_next;
      tmode_reg  <= wr_tmode ? sfr_wdata : tmode_reg;
      sysctl_reg <= wr_sysctl ? sfr_wdata : sysctl_reg;
      rdata_reg  <= rdata_next;
    end
  end

  // count registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t0_reg <= {`DTC_COUNT_RST, `DTC_COUNT_RST};
      t1_reg <= {`DTC_COUNT_RST, `DTC_COUNT_RST};
    end
    else
    begin
      t0_reg <= t0_next;
      t1_reg <= t1_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a register bit
  assign sfr_rdata          = rdata_reg;
  assign t0_overflow_flag   = tctrl_reg[`DTC_T0_OVF_BIT];
  assign t1_overflow_flag   = tctrl_reg[`DTC_T1_OVF_BIT];
  assign ext_irq0_edge_flag = tctrl_reg[`DTC_IRQ0_EDG_BIT];
  assign ext_irq1_edge_flag = tctrl_reg[`DTC_IRQ1_EDG_BIT];

endmodule // dtc_top

// *** tb/dtc_top_properties.sv ***
/*
  Port-level checker of the dual timer/counter, bound to dtc_top.
  Assumes one core_clk domain and arst_n asynchronous, active low.
*/
`timescale 1ns/100ps

module dtc_top_properties (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // acknowledges
  input wire logic       t0_vector_ack,
  input wire logic       t1_vector_ack,
  input wire logic       irq0_ack,
  input wire logic       irq1_ack,
  // flags
  input wire logic       t0_overflow_flag,
  input wire logic       t1_overflow_flag,
  input wire logic       ext_irq0_edge_flag,
  input wire logic       ext_irq1_edge_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers; flags may only clear by ack or a written zero
  wire       w_tc     = sfr_wr && sfr_addr == 8'h88;
  wire       unmapped = !(sfr_addr inside {[8'h88:8'h8D], 8'hB4});
  wire [3:0] flg      = {t1_overflow_flag, t0_overflow_flag, ext_irq1_edge_flag, ext_irq0_edge_flag};

  // a write followed at once by a read of the same place
  sequence s_wr_rd(a);
    sfr_wr && sfr_addr == a ##1 sfr_rd && !sfr_wr && sfr_addr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  property p_unmapped;
    sfr_rd && unmapped |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_t0f_fall;
    $fell(t0_overflow_flag) |-> $past(t0_vector_ack) || $past(w_tc && !sfr_wdata[5]);
  endproperty
  a_t0f_fall: assert property (p_t0f_fall) else $error("t0 flag lost");
  property p_t1f_fall;
    $fell(t1_overflow_flag) |-> $past(t1_vector_ack) || $past(w_tc && !sfr_wdata[7]);
  endproperty
  a_t1f_fall: assert property (p_t1f_fall) else $error("t1 flag lost");
  property p_e0_fall;
    $fell(ext_irq0_edge_flag) |-> $past(irq0_ack) || $past(w_tc && !sfr_wdata[1]);
  endproperty
  a_e0_fall: assert property (p_e0_fall) else $error("irq0 flag lost");
  property p_e1_fall;
    $fell(ext_irq1_edge_flag) |-> $past(irq1_ack) || $past(w_tc && !sfr_wdata[3]);
  endproperty
  a_e1_fall: assert property (p_e1_fall) else $error("irq1 flag lost");
  property p_rd_flags;
    sfr_rd && sfr_addr == 8'h88 |=> {sfr_rdata[7], sfr_rdata[5], sfr_rdata[3], sfr_rdata[1]} == $past(flg);
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read mismatch");
  property p_tc_rw;
    s_wr_rd(8'h88) |=> (sfr_rdata & 8'h55) == ($past(sfr_wdata, 2) & 8'h55);
  endproperty
  a_tc_rw: assert property (p_tc_rw) else $error("run or type bits lost");
  property p_mode_rw;
    s_wr_rd(8'h89) |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("mode register lost");
  property p_sys_rw;
    s_wr_rd(8'hB4) |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  a_sys_rw: assert property (p_sys_rw) else $error("source register lost");
endmodule // dtc_top_properties

bind dtc_top dtc_top_properties dtc_top_properties_i (
  .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .t0_vector_ack(t0_vector_ack),
  .t1_vector_ack(t1_vector_ack), .irq0_ack(irq0_ack), .irq1_ack(irq1_ack),
  .t0_overflow_flag(t0_overflow_flag), .t1_overflow_flag(t1_overflow_flag),
  .ext_irq0_edge_flag(ext_irq0_edge_flag), .ext_irq1_edge_flag(ext_irq1_edge_flag));

// *** tb/dtc_clk_model.sv ***
/*
  Far-side model of the two prescaler clocks.
  Assumes core_clk runs; each output stays low while its enable is low.
*/
`timescale 1ns/100ps

module dtc_clk_model (
  // core clock
  input  wire logic core_clk,
  // enables
  input  wire logic psc_en,
  input  wire logic per_en,
  // slow clocks
  output wire logic psc_clk,
  output wire logic per_clk
);
  logic [3:0] div = 4'h0;

  // psc at core/8, per at core/16: slow enough for the synchronisers
  always @(posedge core_clk)
    div <= div + 4'h1;
  assign psc_clk = psc_en & div[2];
  assign per_clk = per_en & div[3];
endmodule // dtc_clk_model

// *** tb/dual_timer_counter_control_tb.sv ***
/*
  Self-checking bench of the dual timer/counter.
  Assumes dtc_top as the device and dtc_clk_model on its clock inputs.
*/
`timescale 1ns/100ps

module dual_timer_counter_control_tb;
  import dtc_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, fs = 0, is = 0, psc_en = 0, per_en = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [1:0] irq = 2'h3, cpin = 2'h0;
  logic [3:0] ack = 4'h0;
  wire        psc, per;
  wire  [7:0] rdata;
  wire  [3:0] flg;
  int         num_errors = 0, check_count = 0;

  always #50 clk = ~clk;

  dtc_clk_model dtc_clk_model_i (.core_clk(clk), .psc_en(psc_en), .per_en(per_en), .psc_clk(psc), .per_clk(per));
  dtc_top dtc_top_i (
    .core_clk(clk), .arst_n(rst_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd),
    .sfr_rdata(rdata), .ext_irq0_pin(irq[0]), .ext_irq1_pin(irq[1]), .t0_count_pin(cpin[0]),
    .t1_count_pin(cpin[1]), .psc_clk(psc), .per_clk(per), .program_fetch_strobe(fs), .instr_strobe(is),
    .t0_vector_ack(ack[2]), .t1_vector_ack(ack[3]), .irq0_ack(ack[0]), .irq1_ack(ack[1]),
    .t0_overflow_flag(flg[2]), .t1_overflow_flag(flg[3]), .ext_irq0_edge_flag(flg[0]),
    .ext_irq1_edge_flag(flg[1]));

  ////////////////////////////////////////////////////////////////////////
  // report and compare
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register port and stimulus helpers, all driven on falling edges
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); addr = a; wd = d; wr = 1;
    @(negedge clk); wr = 0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge clk); addr = a; rd = 1;
    @(negedge clk); rd = 0;
    chk8(rdata & m, e);
  endtask
  // back-to-back write then read of one place
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); addr = a; wd = d; wr = 1;
    @(negedge clk); wr = 0; rd = 1;
    @(negedge clk); rd = 0;
    chk8(rdata, d);
  endtask
  task automatic stb(input int n, input bit t1);
    repeat (n)
    begin
      @(negedge clk); fs = t1; is = !t1;
      @(negedge clk); fs = 0; is = 0;
    end
  endtask
  task automatic ackp(input int i);
    @(negedge clk); ack[i] = 1;
    @(negedge clk); ack[i] = 0;
  endtask
  // bounded wait for one flag; running out ends the run
  task automatic wflag(input int i, input logic v);
    for (int k = 0; k < 400 && flg[i] !== v; k++)
      @(negedge clk);
    chkb(flg[i], v);
    if (flg[i] !== v)
      finish_test();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd8(8'h88, 8'h00); rd8(8'h89, 8'h00); rd8(8'hB4, 8'h00); rd8(8'h8A, 8'h00);
    wr8(8'h90, 8'h5A); rd8(8'h90, 8'h00);
    wrrd(8'h89, 8'h5A); wrrd(8'hB4, 8'hA5); wrrd(8'h88, 8'h05); wrrd(8'h8D, 8'h3C);
    wr8(8'h88, 8'h00); wr8(8'h89, 8'h00); wr8(8'hB4, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_wide;
    wr8(8'hB4, 8'h20); wr8(8'h89, 8'h01); wr8(8'h8A, 8'hFE); wr8(8'h8C, 8'hFF); wr8(8'h88, 8'h10);
    stb(2, 0); rd8(8'h8A, 8'h00); rd8(8'h8C, 8'h00); chkb(flg[2], 1);
    ackp(2); chkb(flg[2], 0);
    wr8(8'h88, 8'h00); stb(3, 0); rd8(8'h8A, 8'h00);
    wr8(8'h88, 8'h10); stb(1, 0); rd8(8'h8A, 8'h01);
    $display("test wide done");
  endtask
  task automatic t_reload;
    wr8(8'h89, 8'h02); wr8(8'h8A, 8'hFF); wr8(8'h8C, 8'h40);
    stb(1, 0); rd8(8'h8A, 8'h40); rd8(8'h8C, 8'h40); chkb(flg[2], 1);
    wr8(8'h88, 8'h10); chkb(flg[2], 0);
    stb(1, 0); rd8(8'h8A, 8'h41);
    $display("test reload done");
  endtask
  task automatic t_legacy;
    wr8(8'h89, 8'h00); wr8(8'h8A, 8'h1F); wr8(8'h8C, 8'hFF);
    stb(1, 0); rd8(8'h8A, 8'h00, 8'h1F); rd8(8'h8C, 8'h00); chkb(flg[2], 1);
    stb(32, 0); rd8(8'h8C, 8'h01);
    wr8(8'h88, 8'h00);
    $display("test legacy done");
  endtask
  task automatic t_t1;
    wr8(8'hB4, 8'h80); wr8(8'h89, 8'h10); wr8(8'h8B, 8'hFF); wr8(8'h8D, 8'h00); wr8(8'h88, 8'h40);
    stb(1, 1); rd8(8'h8B, 8'h00); rd8(8'h8D, 8'h01);
    wr8(8'h89, 8'h30); stb(2, 1); rd8(8'h8B, 8'h00);
    wr8(8'hB4, 8'h40); wr8(8'h89, 8'h10); pinp(3, 1); rd8(8'h8B, 8'h03);
    wr8(8'h88, 8'h00);
    $display("test timer1 done");
  endtask
  task automatic pinp(input int n, input int p = 0);
    repeat (n)
    begin
      @(negedge clk); cpin[p] = 1;
      repeat (4) @(negedge clk);
      cpin[p] = 0;
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic t_gate;
    wr8(8'hB4, 8'h00); wr8(8'h89, 8'h0D); wr8(8'h8A, 8'h00); wr8(8'h88, 8'h10);
    irq[0] = 0; pinp(2); rd8(8'h8A, 8'h00);
    irq[0] = 1; pinp(2); rd8(8'h8A, 8'h02);
    wr8(8'h88, 8'h00);
    $display("test gate done");
  endtask
  task automatic t_split;
    wr8(8'h89, 8'h03); wr8(8'h8C, 8'hFF); wr8(8'h88, 8'h40); psc_en = 1;
    wflag(3, 1); chkb(flg[2], 0);
    ackp(3); chkb(flg[3], 0);
    psc_en = 0; wr8(8'h88, 8'h00);
    $display("test split done");
  endtask
  task automatic t_src;
    for (int i = 0; i < 2; i++)
    begin
      // enable the slow clocks first so an enable glitch lands before the run window
      psc_en = 1; per_en = 1;
      wr8(8'hB4, i ? 8'h30 : 8'h00); wr8(8'h89, 8'h01); wr8(8'h8A, 8'h00); wr8(8'h8C, 8'h00);
      wr8(8'h88, 8'h10);
      repeat (64) @(negedge clk);
      wr8(8'h88, 8'h00); psc_en = 0; per_en = 0;
      rd8(8'h8C, 8'h00); rd8(8'h8A, 8'h00, 8'hF0);
      chkb(rdata >= (i ? 8'h03 : 8'h07) && rdata <= (i ? 8'h05 : 8'h09), 1);
    end
    $display("test sources done");
  endtask
  task automatic t_xirq(input int n);
    wr8(8'h88, 8'h00); chkb(flg[n], 0);
    irq[n] = 0; wflag(n, 1);
    ackp(n); chkb(flg[n], 0);
    irq[n] = 1; repeat (4) @(negedge clk);
    wr8(8'h88, n ? 8'h04 : 8'h01);
    irq[n] = 0; wflag(n, 1);
    ackp(n); chkb(flg[n], 1);
    irq[n] = 1; repeat (4) @(negedge clk);
    ackp(n); chkb(flg[n], 0);
    $display("test irq%0d done", n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset for eight cycles, then every scenario
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    t_regs(); t_wide(); t_reload(); t_legacy(); t_t1(); t_gate(); t_split(); t_src();
    t_xirq(0); t_xirq(1);
    finish_test();
  end
endmodule // dual_timer_counter_control_tb
